// file: design/esc_consts.svh
// register map, field positions, key and vector numbers of the exception state block
`ifndef ESC_CONSTS_SVH
`define ESC_CONSTS_SVH

`define ESC_ADDR_W         16
`define ESC_OFS_CTL_STATE  16'hed04
`define ESC_OFS_TBL_BASE   16'hed08
`define ESC_OFS_RST_CTL    16'hed0c

`define ESC_BIT_NMI_SET    31
`define ESC_BIT_DSVC_SET   28
`define ESC_BIT_DSVC_CLR   27
`define ESC_BIT_TICK_SET   26
`define ESC_BIT_TICK_CLR   25
`define ESC_BIT_PREEMPT    23
`define ESC_BIT_EXT_PEND   22
`define ESC_VPEND_HI       20
`define ESC_VPEND_LO       12
`define ESC_VACT_HI        8
`define ESC_VACT_LO        0

`define ESC_TBASE_HI       31
`define ESC_TBASE_LO       8
`define ESC_TBASE_RST      24'h000000

`define ESC_KEY_HI         31
`define ESC_KEY_LO         16
`define ESC_KEY_VALUE      16'h05fa
`define ESC_BIT_BYTE_ORDER 15
`define ESC_BYTE_ORDER_LE  1'b0
`define ESC_BIT_SYSRST     2
`define ESC_BIT_CLR_ACT    1

`define ESC_VEC_NONE       9'h000
`define ESC_VEC_NMI        9'h002
`define ESC_VEC_DSVC       9'h00e
`define ESC_VEC_TICK       9'h00f
`define ESC_VEC_IRQ0       9'h010

`define ESC_IRQ_MAX        32

`endif

// file: design/esc_pkg.sv
// types shared by the exception state block and its neighbours
package esc_pkg;
`include "esc_consts.svh"

    typedef logic [8:0] esc_vec_t;

    typedef struct packed {
        logic [`ESC_ADDR_W-1:0] addr;
        logic [31:0]            wdata;
        logic                   wr;
        logic                   rd;
        logic                   from_debug;
    } esc_bus_req_t;

    typedef struct packed {
        logic     entry;
        esc_vec_t entry_num;
        logic     ret;
        esc_vec_t ret_num;
    } esc_core_evt_t;
endpackage

// file: design/esc_exception_state_control.sv
// exception pending/active state, vector table base and keyed reset control
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps

module esc_exception_state_control #(
    parameter int IRQ_COUNT = 32
) (
    // clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_sys_rst,
    // register port
    input  wire esc_pkg::esc_bus_req_t    i_bus,
    output logic [31:0]                   o_rdata,
    // core and debug status
    input  wire esc_pkg::esc_core_evt_t   i_core_evt,
    input  wire logic                     i_nmi_req,
    input  wire logic                     i_halted,
    input  wire logic                     i_debug_mask_interrupts,
    input  wire logic [IRQ_COUNT-1:0]     i_irq_pending,
    input  wire logic [IRQ_COUNT-1:0]     i_irq_enable,
    // exception state to the core
    output logic                          o_nmi_pending,
    output logic                          o_dsvc_pending,
    output logic                          o_tick_pending,
    output esc_pkg::esc_vec_t             o_pending_vector_number,
    output esc_pkg::esc_vec_t             o_active_vector_number,
    output logic [31:0]                   o_vector_table_base,
    output logic                          o_clear_active_state,
    // to the outer reset and debug halt logic
    output logic                          o_system_reset_request,
    output logic                          o_debug_halt_clear
);
    import esc_pkg::*;

    // ---------------------------------------------------------------
    // elaboration checks
    // ---------------------------------------------------------------
    if (IRQ_COUNT < 1 || IRQ_COUNT > `ESC_IRQ_MAX)
    begin : g_bad_count
        $error("IRQ_COUNT out of range");
    end

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    logic        wr_state;
    logic        wr_tbase;
    logic        wr_rstctl;
    logic        key_ok;
    logic [31:0] wd;

    // exact word match: misaligned addresses fall out as unmapped
    assign wr_state  = i_bus.wr && (i_bus.addr == `ESC_OFS_CTL_STATE);
    assign wr_tbase  = i_bus.wr && (i_bus.addr == `ESC_OFS_TBL_BASE);
    assign wr_rstctl = i_bus.wr && (i_bus.addr == `ESC_OFS_RST_CTL);
    assign wd        = i_bus.wdata;
    assign key_ok    = (wd[`ESC_KEY_HI:`ESC_KEY_LO] == `ESC_KEY_VALUE);

    // ---------------------------------------------------------------
    // nonmaskable pending
    // ---------------------------------------------------------------
    logic nmi_pend_reg;
    logic nmi_req_d_reg;
    logic nmi_rise;
    logic nmi_entry;

    assign nmi_rise  = i_nmi_req && !nmi_req_d_reg;
    assign nmi_entry = i_core_evt.entry && (i_core_evt.entry_num == `ESC_VEC_NMI);

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            nmi_req_d_reg <= 1'b0;
        else
            nmi_req_d_reg <= i_nmi_req;
    end

    // set beats the entry clear, so a re-assertion inside the handler sticks
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            nmi_pend_reg <= 1'b0;
        else if (nmi_rise || (wr_state && wd[`ESC_BIT_NMI_SET]))
            nmi_pend_reg <= 1'b1;
        else if (nmi_entry)
            nmi_pend_reg <= 1'b0;
    end

    // ---------------------------------------------------------------
    // deferred service pending
    // ---------------------------------------------------------------
    logic dsvc_pend_reg;
    logic dsvc_entry;

    assign dsvc_entry = i_core_evt.entry && (i_core_evt.entry_num == `ESC_VEC_DSVC);

    // software write is the only set path; set wins over both clears
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            dsvc_pend_reg <= 1'b0;
        else if (wr_state && wd[`ESC_BIT_DSVC_SET])
            dsvc_pend_reg <= 1'b1;
        else if ((wr_state && wd[`ESC_BIT_DSVC_CLR]) || dsvc_entry)
            dsvc_pend_reg <= 1'b0;
    end

    // ---------------------------------------------------------------
    // tick timer pending
    // ---------------------------------------------------------------
    logic tick_pend_reg;
    logic tick_entry;

    assign tick_entry = i_core_evt.entry && (i_core_evt.entry_num == `ESC_VEC_TICK);

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            tick_pend_reg <= 1'b0;
        else if (wr_state && wd[`ESC_BIT_TICK_SET])
            tick_pend_reg <= 1'b1;
        else if ((wr_state && wd[`ESC_BIT_TICK_CLR]) || tick_entry)
            tick_pend_reg <= 1'b0;
    end

    // ---------------------------------------------------------------
    // pending vector
    // ---------------------------------------------------------------
    function automatic esc_vec_t lowest_irq(input logic [IRQ_COUNT-1:0] p);
        esc_vec_t v;
        v = `ESC_VEC_NONE;
        for (int i = IRQ_COUNT - 1; i >= 0; i--)
        begin
            if (p[i])
                v = esc_vec_t'(`ESC_VEC_IRQ0 + i);
        end
        return v;
    endfunction

    esc_vec_t pend_vec;
    logic     ext_pend;
    logic     preempt;
    esc_vec_t act_vec_reg;

    // no global priority mask input: it must not hide a pending source
    always_comb
    begin
        if (nmi_pend_reg)
            pend_vec = `ESC_VEC_NMI;
        else if (dsvc_pend_reg)
            pend_vec = `ESC_VEC_DSVC;
        else if (tick_pend_reg)
            pend_vec = `ESC_VEC_TICK;
        else
            pend_vec = lowest_irq(i_irq_pending & i_irq_enable);
    end

    assign ext_pend = |i_irq_pending;

    // fixed priority: a lower number outranks the active one
    assign preempt = i_halted && !i_debug_mask_interrupts &&
                     (pend_vec != `ESC_VEC_NONE) &&
                     ((act_vec_reg == `ESC_VEC_NONE) || (pend_vec < act_vec_reg));

    // ---------------------------------------------------------------
    // active vector and clear-active pulse
    // ---------------------------------------------------------------
    logic clr_act_reg;
    logic clr_act_req;

    assign clr_act_req = wr_rstctl && key_ok && wd[`ESC_BIT_CLR_ACT] &&
                         i_bus.from_debug && i_halted;

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            clr_act_reg <= 1'b0;
        else
            clr_act_reg <= clr_act_req;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            act_vec_reg <= `ESC_VEC_NONE;
        else if (clr_act_req)
            act_vec_reg <= `ESC_VEC_NONE;
        else if (i_core_evt.entry)
            act_vec_reg <= i_core_evt.entry_num;
        else if (i_core_evt.ret)
            act_vec_reg <= i_core_evt.ret_num;
    end

    // ---------------------------------------------------------------
    // vector table base
    // ---------------------------------------------------------------
    logic [23:0] tbase_reg;

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            tbase_reg <= `ESC_TBASE_RST;
        else if (wr_tbase)
            tbase_reg <= wd[`ESC_TBASE_HI:`ESC_TBASE_LO];
    end

    // ---------------------------------------------------------------
    // system reset request
    // ---------------------------------------------------------------
    logic sysrst_reg;

    // held until the outer reset comes back through i_sys_rst
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            sysrst_reg <= 1'b0;
        else if (wr_rstctl && key_ok && wd[`ESC_BIT_SYSRST])
            sysrst_reg <= 1'b1;
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    logic [31:0] rdata_next;
    logic [31:0] rdata_reg;

    // write-only, key and reserved bits all read as zero
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (i_bus.addr)
            `ESC_OFS_CTL_STATE:
            begin
                rdata_next[`ESC_BIT_NMI_SET]  = nmi_pend_reg;
                rdata_next[`ESC_BIT_DSVC_SET] = dsvc_pend_reg;
                rdata_next[`ESC_BIT_TICK_SET] = tick_pend_reg;
                rdata_next[`ESC_BIT_PREEMPT]  = preempt;
                rdata_next[`ESC_BIT_EXT_PEND] = ext_pend;
                rdata_next[`ESC_VPEND_HI:`ESC_VPEND_LO] = pend_vec;
                rdata_next[`ESC_VACT_HI:`ESC_VACT_LO]   = act_vec_reg;
            end
            `ESC_OFS_TBL_BASE:
                rdata_next[`ESC_TBASE_HI:`ESC_TBASE_LO] = tbase_reg;
            `ESC_OFS_RST_CTL:
            begin
                rdata_next[`ESC_BIT_BYTE_ORDER] = `ESC_BYTE_ORDER_LE;
                rdata_next[`ESC_BIT_SYSRST]     = sysrst_reg;
            end
            default:
                rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            rdata_reg <= 32'h0000_0000;
        else if (i_bus.rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= 32'h0000_0000;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_rdata                 = rdata_reg;
    assign o_nmi_pending           = nmi_pend_reg;
    assign o_dsvc_pending          = dsvc_pend_reg;
    assign o_tick_pending          = tick_pend_reg;
    assign o_pending_vector_number = pend_vec;
    assign o_active_vector_number  = act_vec_reg;
    assign o_vector_table_base     = {tbase_reg, 8'h00};
    // core returns to thread mode with exception number 0 on this pulse
    assign o_clear_active_state    = clr_act_reg;
    assign o_system_reset_request  = sysrst_reg;
    // debug link sits outside this reset; only its halt flag is dropped
    assign o_debug_halt_clear      = sysrst_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_clr_req;
        clr_act_req;
    endsequence

    sequence s_clr_done;
        o_clear_active_state ##1 !o_clear_active_state;
    endsequence

    chk_nmi_set_pend: assert property (
        (wr_state && wd[`ESC_BIT_NMI_SET]) |=> o_nmi_pending)
        else $error("nmi set write did not pend");

    chk_nmi_entry_clr: assert property (
        (nmi_entry && !nmi_rise && !(wr_state && wd[`ESC_BIT_NMI_SET]))
        |=> !o_nmi_pending)
        else $error("nmi entry did not clear pending");

    chk_nmi_reassert: assert property (
        (nmi_entry && nmi_rise) |=> o_nmi_pending)
        else $error("nmi re-assertion lost at entry");

    chk_dsvc_sw_only: assert property (
        $rose(o_dsvc_pending) |-> $past(wr_state && wd[`ESC_BIT_DSVC_SET]))
        else $error("deferred service pended without write");

    chk_dsvc_clear: assert property (
        (wr_state && wd[`ESC_BIT_DSVC_CLR] && !wd[`ESC_BIT_DSVC_SET])
        |=> !o_dsvc_pending)
        else $error("deferred service clear failed");

    chk_tick_clear: assert property (
        (wr_state && wd[`ESC_BIT_TICK_CLR] && !wd[`ESC_BIT_TICK_SET])
        |=> !o_tick_pending ##0 !o_rdata[`ESC_BIT_TICK_CLR])
        else $error("tick clear failed");

    chk_preempt_halt: assert property (
        (i_bus.rd && i_bus.addr == `ESC_OFS_CTL_STATE && !i_halted)
        |=> !o_rdata[`ESC_BIT_PREEMPT])
        else $error("preempt visible while running");

    chk_ext_flag: assert property (
        (i_bus.rd && i_bus.addr == `ESC_OFS_CTL_STATE)
        |=> o_rdata[`ESC_BIT_EXT_PEND] == $past(|i_irq_pending))
        else $error("external pending flag wrong");

    chk_vect_none: assert property (
        (!nmi_pend_reg && !dsvc_pend_reg && !tick_pend_reg &&
         ((i_irq_pending & i_irq_enable) == '0))
        |-> o_pending_vector_number == `ESC_VEC_NONE)
        else $error("pending vector not zero when idle");

    chk_tbase_write: assert property (
        wr_tbase |=> o_vector_table_base ==
            {$past(wd[`ESC_TBASE_HI:`ESC_TBASE_LO]), 8'h00})
        else $error("vector table base not written");

    chk_key_ignored: assert property (
        (wr_rstctl && !key_ok && !o_system_reset_request)
        |=> !o_system_reset_request && !o_clear_active_state)
        else $error("unkeyed reset control write acted");

    chk_sysrst_req: assert property (
        (wr_rstctl && key_ok && wd[`ESC_BIT_SYSRST])
        |=> (o_system_reset_request && o_debug_halt_clear) [*2])
        else $error("reset request not held");

    chk_clr_active: assert property (
        s_clr_req ##1 !clr_act_req |-> s_clr_done)
        else $error("clear active not a single pulse");

    chk_clr_vector: assert property (
        s_clr_req |=> o_active_vector_number == `ESC_VEC_NONE)
        else $error("active vector not cleared");

    chk_clr_gate: assert property (
        (wr_rstctl && !(i_bus.from_debug && i_halted)) |=> !o_clear_active_state)
        else $error("clear active without halted debugger");

endmodule // esc_exception_state_control

// file: test/esc_core_model.sv
// behavioural core that takes and leaves exceptions for the exception state block
`timescale 1ns/10ps
`include "esc_consts.svh"

module esc_core_model (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_sys_rst,
    // commands from the bench
    input  wire logic                  i_take,
    input  wire logic                  i_ret,
    // exception state from the block
    input  wire esc_pkg::esc_vec_t     i_pending_vector_number,
    input  wire logic                  i_clear_active_state,
    // events to the block
    output esc_pkg::esc_core_evt_t     o_core_evt
);
    import esc_pkg::*;

    logic in_handler_reg;

    // ------------------------------------------------------------
    // entry and return events
    // ------------------------------------------------------------
    // one entry per one-cycle take; a held take re-enters every other cycle while a source stays pending
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_core_evt <= '0;
        end
        else
        begin
            o_core_evt.entry     <= i_take && !o_core_evt.entry
                                    && (i_pending_vector_number != `ESC_VEC_NONE);
            o_core_evt.entry_num <= i_pending_vector_number;
            o_core_evt.ret       <= i_ret && in_handler_reg;
            o_core_evt.ret_num   <= `ESC_VEC_NONE;
        end
    end

    // ------------------------------------------------------------
    // handler frame
    // ------------------------------------------------------------
    // frame dropped on clear-active, which wins over entry and return
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            in_handler_reg <= 1'b0;
        else if (i_clear_active_state)
            in_handler_reg <= 1'b0;
        else if (o_core_evt.entry)
            in_handler_reg <= 1'b1;
        else if (o_core_evt.ret)
            in_handler_reg <= 1'b0;
    end
endmodule // esc_core_model

// file: test/tb_top.sv
// self-checking bench for the exception state block
`timescale 1ns/10ps
`include "esc_consts.svh"

module tb_top;
    import esc_pkg::*;

    localparam logic [15:0] A_IC  = `ESC_OFS_CTL_STATE;
    localparam logic [15:0] A_VT  = `ESC_OFS_TBL_BASE;
    localparam logic [15:0] A_AI  = `ESC_OFS_RST_CTL;
    localparam logic [31:0] N_SET = 32'h1 << `ESC_BIT_NMI_SET;
    localparam logic [31:0] D_SET = 32'h1 << `ESC_BIT_DSVC_SET;
    localparam logic [31:0] D_CLR = 32'h1 << `ESC_BIT_DSVC_CLR;
    localparam logic [31:0] T_SET = 32'h1 << `ESC_BIT_TICK_SET;
    localparam logic [31:0] T_CLR = 32'h1 << `ESC_BIT_TICK_CLR;
    localparam logic [31:0] EXT   = 32'h1 << `ESC_BIT_EXT_PEND;
    localparam logic [31:0] PRE   = 32'h1 << `ESC_BIT_PREEMPT;

    logic          i_core_clk;
    logic          i_sys_rst;
    esc_bus_req_t  bus;
    esc_core_evt_t evt;
    logic [31:0]   rdata, irq_pend, irq_en, vbase, rd_val;
    logic          nmi_req, halted, mask_ints, take, ret;
    logic          nmi_p, dsvc_p, tick_p, clr_act, rst_req, halt_clr;
    esc_vec_t      pvec, avec;
    int            failures, checks, cycles;

    esc_exception_state_control #(.IRQ_COUNT(32)) DUT (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata),
        .i_core_evt(evt), .i_nmi_req(nmi_req), .i_halted(halted),
        .i_debug_mask_interrupts(mask_ints), .i_irq_pending(irq_pend), .i_irq_enable(irq_en),
        .o_nmi_pending(nmi_p), .o_dsvc_pending(dsvc_p), .o_tick_pending(tick_p),
        .o_pending_vector_number(pvec), .o_active_vector_number(avec),
        .o_vector_table_base(vbase), .o_clear_active_state(clr_act),
        .o_system_reset_request(rst_req), .o_debug_halt_clear(halt_clr));

    esc_core_model core (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_take(take), .i_ret(ret),
        .i_pending_vector_number(pvec), .i_clear_active_state(clr_act), .o_core_evt(evt));

    initial
    begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d, input logic dbg);
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, from_debug: dbg};
        @(posedge i_core_clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1, from_debug: 1'b0};
        @(posedge i_core_clk);
        bus.rd <= 1'b0;
        #1;
        check(rdata, exp, "read data");
    endtask

    task automatic pulse_core(input logic is_take);
        @(posedge i_core_clk);
        if (is_take) take <= 1'b1; else ret <= 1'b1;
        @(posedge i_core_clk);
        take <= 1'b0;
        ret  <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask

    function automatic logic [31:0] interrupt_control_state(input logic [31:0] f, input esc_vec_t pv,
                                         input esc_vec_t av);
        return f | {11'h0, pv, 3'h0, av};
    endfunction

    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard, well above the 120 or so cycles the tests need
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            $display("ERROR at %0t: cycle ceiling reached", $time);
            close_out();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        {failures, checks} = '0;
        bus = '0;
        {nmi_req, halted, mask_ints, take, ret} = '0;
        irq_pend = 32'h0;
        irq_en = 32'h0;
        i_sys_rst = 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        rd_chk(A_IC, 32'h0);
        rd_chk(A_VT, 32'h0);
        rd_chk(A_AI, 32'h0);
        $display("done: reset values");
        reg_wr(A_IC, D_SET, 1'b0);
        check(dsvc_p, 1'b1, "dsvc set");
        rd_chk(A_IC, interrupt_control_state(D_SET, `ESC_VEC_DSVC, 9'h0));
        reg_wr(A_IC, 32'h0, 1'b0);
        check(dsvc_p, 1'b1, "dsvc zero write");
        reg_wr(A_IC, D_CLR, 1'b0);
        check(dsvc_p, 1'b0, "dsvc clear");
        reg_wr(A_IC, D_SET | D_CLR, 1'b0);
        check(dsvc_p, 1'b1, "dsvc set beats clear");
        reg_wr(A_IC, T_SET, 1'b0);
        rd_chk(A_IC, interrupt_control_state(D_SET | T_SET, `ESC_VEC_DSVC, 9'h0));
        reg_wr(A_IC, D_CLR, 1'b0);
        rd_chk(A_IC, interrupt_control_state(T_SET, `ESC_VEC_TICK, 9'h0));
        reg_wr(A_IC, T_CLR, 1'b0);
        check(tick_p, 1'b0, "tick clear");
        $display("done: deferred service and tick");
        @(posedge i_core_clk);
        irq_pend <= 32'h20;
        @(posedge i_core_clk);
        #1;
        check(pvec, 9'h0, "disabled irq hidden");
        rd_chk(A_IC, EXT);
        @(posedge i_core_clk);
        irq_pend <= 32'h28;
        irq_en   <= 32'h28;
        rd_chk(A_IC, interrupt_control_state(EXT, `ESC_VEC_IRQ0 + 9'h3, 9'h0));
        check(dsvc_p, 1'b0, "dsvc untouched by irq");
        @(posedge i_core_clk);
        halted <= 1'b1;
        rd_chk(A_IC, interrupt_control_state(EXT | PRE, `ESC_VEC_IRQ0 + 9'h3, 9'h0));
        @(posedge i_core_clk);
        mask_ints <= 1'b1;
        rd_chk(A_IC, interrupt_control_state(EXT, `ESC_VEC_IRQ0 + 9'h3, 9'h0));
        @(posedge i_core_clk);
        {halted, mask_ints, irq_pend, irq_en} <= '0;
        $display("done: external pending and preempt");
        reg_wr(A_IC, N_SET, 1'b0);
        check(nmi_p, 1'b1, "nmi set");
        rd_chk(A_IC, interrupt_control_state(N_SET, `ESC_VEC_NMI, 9'h0));
        pulse_core(1'b1);
        check(nmi_p, 1'b0, "nmi entry clears");
        rd_chk(A_IC, interrupt_control_state(32'h0, 9'h0, `ESC_VEC_NMI));
        @(posedge i_core_clk);
        nmi_req <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        nmi_req <= 1'b0;
        rd_chk(A_IC, interrupt_control_state(N_SET, `ESC_VEC_NMI, `ESC_VEC_NMI));
        check(dsvc_p, 1'b0, "dsvc untouched by nmi");
        pulse_core(1'b0);
        check(avec, 9'h0, "return to thread");
        @(posedge i_core_clk);
        take <= 1'b1;
        @(posedge i_core_clk);
        take    <= 1'b0;
        nmi_req <= 1'b1;
        @(posedge i_core_clk);
        nmi_req <= 1'b0;
        #1;
        check(nmi_p, 1'b1, "nmi rise at entry kept");
        pulse_core(1'b1);
        check(nmi_p, 1'b0, "nmi retaken and cleared");
        check(avec, `ESC_VEC_NMI, "nmi active");
        $display("done: nonmaskable");
        reg_wr(A_AI, 32'h05fa0002, 1'b1);
        check(avec, `ESC_VEC_NMI, "clear refused while running");
        @(posedge i_core_clk);
        halted <= 1'b1;
        reg_wr(A_AI, 32'h05fa0002, 1'b0);
        check(clr_act, 1'b0, "clear refused from software");
        reg_wr(A_AI, 32'h05fb0002, 1'b1);
        check(clr_act, 1'b0, "clear refused on bad key");
        reg_wr(A_AI, 32'h05fa0002, 1'b1);
        check(clr_act, 1'b1, "clear pulse");
        check(avec, 9'h0, "active emptied");
        @(posedge i_core_clk);
        #1;
        check(clr_act, 1'b0, "clear self-clears");
        rd_chk(A_AI, 32'h0);
        @(posedge i_core_clk);
        halted <= 1'b0;
        $display("done: clear active");
        reg_wr(A_VT, 32'hdeadbeef, 1'b0);
        rd_chk(A_VT, 32'hdeadbe00);
        check(vbase, 32'hdeadbe00, "table base");
        reg_wr(A_VT + 16'h1, 32'hffffffff, 1'b0);
        rd_chk(A_VT + 16'h1, 32'h0);
        rd_chk(A_VT, 32'hdeadbe00);
        reg_wr(A_IC, 32'h00fff1ff, 1'b0);
        rd_chk(A_IC, 32'h0);
        $display("done: table base and reserved");
        reg_wr(A_AI, 32'h05fb0004, 1'b0);
        check(rst_req, 1'b0, "request needs key");
        reg_wr(A_AI, 32'h05fa0004, 1'b0);
        check(rst_req, 1'b1, "reset request");
        check(halt_clr, 1'b1, "halt cleared");
        repeat (10) @(posedge i_core_clk);
        rd_chk(A_AI, 32'h00000004);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        #1;
        check(rst_req, 1'b0, "request dropped by reset");
        rd_chk(A_VT, 32'h0);
        $display("done: reset request");
        close_out();
    end
endmodule // tb_top
